// ---- hdl/mpc_base_field.sv ----
// One writable base-address field with fixed zero low bits
`timescale 1ns/10ps
`include "mpc_regs.svh"
module mpc_base_field #(
   parameter int HI = 15,
   parameter int LO = 10
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic wr_en,
   input wire logic [31:0] wr_data,
   input wire logic [3:0] byte_en,
   output logic [31:0] value
);
   // ---------------------------------------------------------------
   // Field storage
   // ---------------------------------------------------------------
   logic [HI-LO:0] field_q;
   logic [31:0] merged;
   logic [31:0] mask;

   // Byte lanes select which incoming bits land on the field
   always_comb begin
      mask = {{8{byte_en[3]}}, {8{byte_en[2]}}, {8{byte_en[1]}}, {8{byte_en[0]}}};
      merged = (wr_data & mask) | (value & ~mask);
   end

   // Cleared at reset; only HI..LO ever hold state
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         field_q <= '0;
      end else if (wr_en) begin
         field_q <= merged[HI:LO];
      end
   end

   // Bits outside the field are wired to zero so granularity holds
   always_comb begin
      value = `MPC_ZERO32;
      value[HI:LO] = field_q;
   end
endmodule

// ---- hdl/mpc_config_regs.sv ----
// Avalon-MM register bank that partitions data RAM and program flash
//
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/10ps
`include "mpc_regs.svh"
module mpc_config_regs #(
   parameter logic [31:0] RAM_SIZE = `MPC_RAM_SIZE_DEF,
   parameter logic [31:0] FLASH_SIZE = `MPC_FLASH_SIZE_DEF
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [1:0] avs_response,
   output logic [31:0] ram_kernel_code_base,
   output logic [31:0] ram_user_data_base,
   output logic [31:0] ram_user_code_base,
   output logic [31:0] flash_user_code_base,
   output logic ram_user_code_active,
   output logic ram_user_data_active,
   output logic partition_order_error
);
   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   mpc_pkg::mpc_state_t state_q;
   mpc_pkg::mpc_sel_t sel;
   logic [31:0] kcb_val;
   logic [31:0] udb_val;
   logic [31:0] ucb_val;
   logic [31:0] fcb_val;
   logic [31:0] rd_mux;
   logic wr_take;
   logic [2:0] wr_vec;
   logic [31:0] geometry;

   // Flash organisation reported to software
   assign geometry = {`MPC_FLASH_PAGE_BYTES, `MPC_FLASH_ROW_BYTES};

   // Address map; anything unmapped answers with an error response
   always_comb begin
      case (avs_address)
         `MPC_OFS_RAM_KERNEL_CODE_BASE: sel = mpc_pkg::MPC_SEL_KCB;
         `MPC_OFS_RAM_USER_DATA_BASE: sel = mpc_pkg::MPC_SEL_UDB;
         `MPC_OFS_RAM_USER_CODE_BASE: sel = mpc_pkg::MPC_SEL_UCB;
         `MPC_OFS_RAM_SIZE: sel = mpc_pkg::MPC_SEL_RSZ;
         `MPC_OFS_FLASH_USER_CODE_BASE: sel = mpc_pkg::MPC_SEL_FCB;
         `MPC_OFS_FLASH_SIZE: sel = mpc_pkg::MPC_SEL_FSZ;
         `MPC_OFS_BOOT_FLASH_SIZE: sel = mpc_pkg::MPC_SEL_BSZ;
         `MPC_OFS_FLASH_GEOMETRY: sel = mpc_pkg::MPC_SEL_GEO;
         default: sel = mpc_pkg::MPC_SEL_NONE;
      endcase
   end

   // ---------------------------------------------------------------
   // Bus handshake
   // ---------------------------------------------------------------
   // Write lands once, in the cycle the request is first seen idle
   assign wr_take = (state_q == mpc_pkg::MPC_IDLE) && avs_write;

   // Idle, then one response cycle with waitrequest low, then a gap
   // cycle so a held request is never taken twice
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= mpc_pkg::MPC_IDLE;
      end else begin
         case (state_q)
            mpc_pkg::MPC_IDLE: begin
               if (avs_read || avs_write) begin
                  state_q <= mpc_pkg::MPC_RESP;
               end
            end
            mpc_pkg::MPC_RESP: state_q <= mpc_pkg::MPC_DONE;
            mpc_pkg::MPC_DONE: state_q <= mpc_pkg::MPC_IDLE;
            default: state_q <= mpc_pkg::MPC_IDLE;
         endcase
      end
   end

   // Waitrequest is high except in the single answer cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !((state_q == mpc_pkg::MPC_IDLE) && (avs_read || avs_write));
      end
   end

   // ---------------------------------------------------------------
   // Writable base fields
   // ---------------------------------------------------------------
   // Only the three RAM bases and the flash base hold state; size and
   // geometry words have no write path at all
   assign wr_vec = {wr_take && (sel == mpc_pkg::MPC_SEL_UCB),
                    wr_take && (sel == mpc_pkg::MPC_SEL_UDB),
                    wr_take && (sel == mpc_pkg::MPC_SEL_KCB)};

   // Same 1 KB field for all three RAM bases
   genvar gi;
   logic [31:0] ram_vals [3];
   generate
      for (gi = 0; gi < 3; gi++) begin : g_ram
         mpc_base_field #(
            .HI(`MPC_RAM_BASE_HI),
            .LO(`MPC_RAM_BASE_LO)
         ) u_field (
            .clk(clk),
            .reset_n(reset_n),
            .wr_en(wr_vec[gi]),
            .wr_data(avs_writedata),
            .byte_en(avs_byteenable),
            .value(ram_vals[gi])
         );
      end
   endgenerate
   assign kcb_val = ram_vals[0];
   assign udb_val = ram_vals[1];
   assign ucb_val = ram_vals[2];

   // Flash base in 2 KB steps, upper bits unimplemented
   mpc_base_field #(
      .HI(`MPC_FLASH_BASE_HI),
      .LO(`MPC_FLASH_BASE_LO)
   ) u_flash_field (
      .clk(clk),
      .reset_n(reset_n),
      .wr_en(wr_take && (sel == mpc_pkg::MPC_SEL_FCB)),
      .wr_data(avs_writedata),
      .byte_en(avs_byteenable),
      .value(fcb_val)
   );

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   // Size words are fixed constants
   always_comb begin
      case (sel)
         mpc_pkg::MPC_SEL_KCB: rd_mux = kcb_val;
         mpc_pkg::MPC_SEL_UDB: rd_mux = udb_val;
         mpc_pkg::MPC_SEL_UCB: rd_mux = ucb_val;
         mpc_pkg::MPC_SEL_RSZ: rd_mux = RAM_SIZE;
         mpc_pkg::MPC_SEL_FCB: rd_mux = fcb_val;
         mpc_pkg::MPC_SEL_FSZ: rd_mux = FLASH_SIZE;
         mpc_pkg::MPC_SEL_BSZ: rd_mux = `MPC_BOOT_FLASH_SIZE;
         mpc_pkg::MPC_SEL_GEO: rd_mux = geometry;
         default: rd_mux = `MPC_ZERO32;
      endcase
   end

   // Read data registered into the answer cycle; zero otherwise
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         avs_readdata <= `MPC_ZERO32;
      end else if ((state_q == mpc_pkg::MPC_IDLE) && avs_read) begin
         avs_readdata <= rd_mux;
      end else begin
         avs_readdata <= `MPC_ZERO32;
      end
   end

   // SLVERR for unmapped addresses, OKAY otherwise
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         avs_response <= 2'h0;
      end else if ((state_q == mpc_pkg::MPC_IDLE) && (avs_read || avs_write)) begin
         avs_response <= (sel == mpc_pkg::MPC_SEL_NONE) ? 2'h2 : 2'h0;
      end else begin
         avs_response <= 2'h0;
      end
   end

   // ---------------------------------------------------------------
   // Partition outputs
   // ---------------------------------------------------------------
   // Registered copies so every output comes from a flop; they trail
   // the field by one cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ram_kernel_code_base <= `MPC_ZERO32;
         ram_user_data_base <= `MPC_ZERO32;
         ram_user_code_base <= `MPC_ZERO32;
         flash_user_code_base <= `MPC_ZERO32;
      end else begin
         ram_kernel_code_base <= kcb_val;
         ram_user_data_base <= udb_val;
         ram_user_code_base <= ucb_val;
         flash_user_code_base <= fcb_val;
      end
   end

   // User program region exists only while its base is nonzero
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ram_user_code_active <= 1'b0;
         ram_user_data_active <= 1'b0;
      end else begin
         ram_user_code_active <= (ucb_val != `MPC_ZERO32);
         ram_user_data_active <= (udb_val != `MPC_ZERO32);
      end
   end

   // Hardware does not enforce ordering; it only flags a bad layout
   // so the system can notice
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         partition_order_error <= 1'b0;
      end else begin
         partition_order_error <= ((ucb_val != `MPC_ZERO32) && (ucb_val <= udb_val)) ||
                                  ((udb_val != `MPC_ZERO32) && (udb_val <= kcb_val)) ||
                                  (ucb_val > RAM_SIZE) || (udb_val > RAM_SIZE) ||
                                  (kcb_val > RAM_SIZE);
      end
   end
endmodule

// ---- shared/mpc_pkg.sv ----
// Types shared by the memory partition configuration block
package mpc_pkg;
   // ---------------------------------------------------------------
   // Bus slave states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      MPC_IDLE = 3'h1,
      MPC_RESP = 3'h2,
      MPC_DONE = 3'h4
   } mpc_state_t;

   // Decoded register selector
   typedef enum logic [3:0] {
      MPC_SEL_KCB = 4'h0,
      MPC_SEL_UDB = 4'h1,
      MPC_SEL_UCB = 4'h2,
      MPC_SEL_RSZ = 4'h3,
      MPC_SEL_FCB = 4'h4,
      MPC_SEL_FSZ = 4'h5,
      MPC_SEL_BSZ = 4'h6,
      MPC_SEL_GEO = 4'h7,
      MPC_SEL_NONE = 4'h8
   } mpc_sel_t;
endpackage

// ---- shared/mpc_regs.svh ----
// Register offsets, field positions and constants of the memory partition configuration block
`ifndef MPC_REGS_SVH
`define MPC_REGS_SVH

// ---------------------------------------------------------------
// Register byte offsets (word aligned)
// ---------------------------------------------------------------
`define MPC_OFS_RAM_KERNEL_CODE_BASE 8'h00
`define MPC_OFS_RAM_USER_DATA_BASE 8'h04
`define MPC_OFS_RAM_USER_CODE_BASE 8'h08
`define MPC_OFS_RAM_SIZE 8'h0C
`define MPC_OFS_FLASH_USER_CODE_BASE 8'h10
`define MPC_OFS_FLASH_SIZE 8'h14
`define MPC_OFS_BOOT_FLASH_SIZE 8'h18
`define MPC_OFS_FLASH_GEOMETRY 8'h1C

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define MPC_RAM_BASE_HI 15
`define MPC_RAM_BASE_LO 10
`define MPC_FLASH_BASE_HI 19
`define MPC_FLASH_BASE_LO 11

// ---------------------------------------------------------------
// Reset values and size constants
// ---------------------------------------------------------------
`define MPC_RAM_BASE_RST 6'h00
`define MPC_FLASH_BASE_RST 9'h000
`define MPC_RAM_SIZE_DEF 32'h00020000
`define MPC_FLASH_SIZE_DEF 32'h00080000
`define MPC_BOOT_FLASH_SIZE 32'h00003000
`define MPC_FLASH_PAGE_BYTES 16'h1000
`define MPC_FLASH_ROW_BYTES 16'h0200
`define MPC_ZERO32 32'h00000000
`define MPC_ADDR_MSB 7

`endif

// ---- test/mpc_config_regs_sva.sv ----
// Concurrent checks on the ports of the memory partition register bank
`timescale 1ns/10ps
module mpc_config_regs_sva #(
   parameter logic [31:0] RAM_SIZE = 32'h00020000,
   parameter logic [31:0] FLASH_SIZE = 32'h00080000
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [31:0] ram_user_code_base,
   input wire logic [31:0] flash_user_code_base
);
   // ---------------------------------------------
   // Transfer shapes
   // ---------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Read of one offset, ending in its answer cycle
   sequence s_rd(logic [7:0] ofs);
      avs_read && avs_address == ofs && avs_waitrequest ##1 avs_read && !avs_waitrequest;
   endsequence
   // Full-word write, so every lane reaches the field
   sequence s_wr(logic [7:0] ofs);
      avs_write && avs_address == ofs && avs_byteenable == 4'hF && avs_waitrequest ##1 avs_write && !avs_waitrequest;
   endsequence
   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   a_reset_clears_bases: assert property ($rose(reset_n) |-> ram_user_code_base == 32'h0 && flash_user_code_base == 32'h0)
      else $error("base not cleared after reset");
   a_ram_fixed_bits: assert property (ram_user_code_base[9:0] == 10'h000 && ram_user_code_base[31:16] == 16'h0000)
      else $error("ram base fixed bits not zero");
   a_flash_fixed_bits: assert property ((flash_user_code_base & 32'hFFF007FF) == 32'h0)
      else $error("flash base fixed bits not zero");
   a_ram_size_read: assert property (s_rd(8'h0C) |-> avs_readdata == RAM_SIZE)
      else $error("ram size read wrong");
   a_flash_size_read: assert property (s_rd(8'h14) |-> avs_readdata == FLASH_SIZE)
      else $error("flash size read wrong");
   a_boot_size_read: assert property (s_rd(8'h18) |-> avs_readdata == 32'h00003000)
      else $error("boot size read wrong");
   a_geometry_read: assert property (s_rd(8'h1C) |-> avs_readdata == 32'h10000200)
      else $error("geometry read wrong");
   a_ram_base_write: assert property (s_wr(8'h08) |=> ram_user_code_base == ($past(avs_writedata) & 32'h0000FC00))
      else $error("ram base write not taken");
   a_flash_base_write: assert property (s_wr(8'h10) |=> flash_user_code_base == ($past(avs_writedata) & 32'h000FF800))
      else $error("flash base write not taken");
   // Answer lasts one cycle, then the dead cycle
   a_single_answer: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer longer than one cycle");
endmodule

// ---- test/tb.sv ----
// Self-checking bench for the memory partition register bank
`timescale 1ns/10ps
module tb;
   // ---------------------------------------------
   // Signals, reference model and counters
   // ---------------------------------------------
   localparam logic [31:0] RAM_SIZE = 32'h00004000;
   localparam logic [31:0] FLASH_SIZE = 32'h00040000;
   logic clk, reset_n, avs_read, avs_write, avs_waitrequest;
   logic [7:0] avs_address, a;
   logic [31:0] avs_writedata, avs_readdata, r;
   logic [3:0] avs_byteenable;
   logic [1:0] avs_response;
   logic [31:0] ram_kernel_code_base, ram_user_data_base, ram_user_code_base, flash_user_code_base;
   logic ram_user_code_active, ram_user_data_active, partition_order_error;
   logic [31:0] m [0:7];
   logic [31:0] wm [0:7];
   int fails, checks_done;

   mpc_config_regs #(.RAM_SIZE(RAM_SIZE), .FLASH_SIZE(FLASH_SIZE)) u_dut (
      .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .ram_kernel_code_base(ram_kernel_code_base),
      .ram_user_data_base(ram_user_data_base), .ram_user_code_base(ram_user_code_base),
      .flash_user_code_base(flash_user_code_base), .ram_user_code_active(ram_user_code_active),
      .ram_user_data_active(ram_user_data_active), .partition_order_error(partition_order_error));

   // Free-running 200 MHz clock
   always #2.5 clk = ~clk;

   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         fails++;
      end
   endtask

   task automatic finish_test();
      if (fails == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Model state after reset: bases clear, sizes fixed
   task automatic mreset();
      m = '{32'h0, 32'h0, 32'h0, RAM_SIZE, 32'h0, FLASH_SIZE, 32'h00003000, 32'h10000200};
   endtask

   // One Avalon transfer; held until waitrequest is sampled low
   task automatic acc(input logic wr, input logic [7:0] ad, input logic [31:0] d, input logic [3:0] be);
      int n;
      logic [31:0] bm;
      logic oe;
      n = 0;
      bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      avs_address <= ad;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_read <= !wr;
      avs_write <= wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) begin
         n++;
         if (n > 20) begin
            fails++;
            finish_test();
         end
         @(posedge clk);
      end
      if (!wr) begin
         oe = (m[2] != 0 && m[2] <= m[1]) || (m[1] != 0 && m[1] <= m[0]) || m[0] > RAM_SIZE || m[1] > RAM_SIZE;
         oe = oe || m[2] > RAM_SIZE;
         check("readdata", avs_readdata, ad < 8'h20 ? m[ad[4:2]] : 32'h0);
         check("response", {30'h0, avs_response}, ad < 8'h20 ? 32'h0 : 32'h2);
         check("ucb_out", ram_user_code_base, m[2]);
         check("fcb_out", flash_user_code_base, m[4]);
         check("kcb_out", ram_kernel_code_base, m[0]);
         check("udb_out", ram_user_data_base, m[1]);
         check("udb_active", {31'h0, ram_user_data_active}, {31'h0, m[1] != 0});
         check("ucb_active", {31'h0, ram_user_code_active}, {31'h0, m[2] != 0});
         check("order_error", {31'h0, partition_order_error}, {31'h0, oe});
      end else if (ad < 8'h20) begin
         m[ad[4:2]] = (m[ad[4:2]] & ~(wm[ad[4:2]] & bm)) | (d & wm[ad[4:2]] & bm);
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask

   // Read every mapped offset and one unmapped
   task automatic rdall();
      for (int i = 0; i < 9; i++) begin
         acc(1'b0, 8'(i * 4), 32'h0, 4'h0);
      end
   endtask

   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
      fails = 0;
      checks_done = 0;
      r = 32'hFFB4;
      wm = '{32'h0000FC00, 32'h0000FC00, 32'h0000FC00, 32'h0, 32'h000FF800, 32'h0, 32'h0, 32'h0};
      mreset();
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rdall();
      // Well-ordered partition, then all-ones into both user code bases (RAM and flash)
      acc(1'b1, 8'h00, 32'h00000400, 4'hF);
      acc(1'b1, 8'h04, 32'h00000800, 4'hF);
      acc(1'b1, 8'h08, 32'h00000C00, 4'hF);
      rdall();
      acc(1'b1, 8'h08, 32'hFFFFFFFF, 4'hF);
      acc(1'b1, 8'h10, 32'hFFFFFFFF, 4'hF);
      rdall();
      // Random reads or writes (r[0] picks) with random lanes, each read back
      for (int k = 0; k < 64; k++) begin
         r = lfsr(r);
         a = 8'((r[11:8] % 9) * 4);
         acc(r[0], a, lfsr(r), r[7:4]);
         acc(1'b0, a, 32'h0, 4'h0);
      end
      // Reset in mid-run must clear the bases again
      reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      check("wait_in_reset", {31'h0, avs_waitrequest}, 32'h1);
      reset_n <= 1'b1;
      mreset();
      @(posedge clk);
      rdall();
      finish_test();
   end
endmodule

bind mpc_config_regs mpc_config_regs_sva #(.RAM_SIZE(RAM_SIZE), .FLASH_SIZE(FLASH_SIZE)) u_sva (
   .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .ram_user_code_base(ram_user_code_base),
   .flash_user_code_base(flash_user_code_base));
